// ### verilog/alarm_threshold_pkg.sv
// Constants and carrier types for the input alarm threshold register block
// Contract
// R1: Bits 31-24 of upper register hold hysteresis, reset 00h; only upper nibble used.
// R2: Host writes zeros into low four hysteresis bits.
// R3: Bits 15-0 of upper register hold upper limit, reset FFFFh; compare bits 15:2.
// R4: Host writes zeros into two low upper-limit bits.
// R5: Bits 15-0 of lower register hold lower limit, reset 0000h; compare bits 15:2.
// R6: Host writes zeros into two low lower-limit bits.
// R7: Upper register bits 23-16 read 00h and ignore writes.
// R8: Lower register bits 31-16 read 0000h and ignore writes.
// R9: Upper register occupies byte addresses 24h to 27h, low byte first.
// R10: Lower register occupies byte addresses 28h to 2Bh, low byte first.
// R11: Separate active and tripped flags for input over and under conditions.
// R12: Overall alarm summary bit 0 of status is OR of tripped flags.
// R13: Over asserts above upper limit, releases below limit minus hysteresis; under symmetric.
`default_nettype none
package alarm_threshold_pkg;
    localparam logic [7:0] ADDR_UPPER = 8'h24;
    localparam logic [7:0] ADDR_LOWER = 8'h28;
    localparam logic [7:0] ADDR_STATUS = 8'h20;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h30;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h34;
    localparam logic [7:0] ADDR_RESULT = 8'h38;
    localparam logic [7:0] RESET_HYST = 8'h00;
    localparam logic [15:0] RESET_UPPER = 16'hffff;
    localparam logic [15:0] RESET_LOWER = 16'h0000;
    localparam int SUMMARY_BIT = 0;
    localparam int TRIP_OVER_BIT = 4;
    localparam int TRIP_UNDER_BIT = 5;
    localparam int ACT_OVER_BIT = 10;
    localparam int ACT_UNDER_BIT = 11;
    localparam logic [31:0] READ_IDLE = 32'h00000000;
    localparam logic [7:0] RSV_UPPER = 8'h00;
    localparam logic [15:0] RSV_LOWER = 16'h0000;
    localparam logic [15:0] LIMIT_MIN = 16'h0000;
    localparam logic [15:0] LIMIT_MAX = 16'hffff;
    localparam int LANES = 4;
    localparam int BYTE_W = 8;
    localparam int LIMIT_W = 16;
    localparam int LIMIT_LSB = 0;
    localparam int HYST_LSB = 24;
    localparam int HYST_USED_LSB = 4;
    localparam int HYST_W = 4;
    localparam int CMP_LSB = 2;
    localparam int IRQ_LSB = 0;
    localparam int IRQ_MSB = 1;
    localparam int IRQ_OVER_BIT = 0;
    localparam int IRQ_UNDER_BIT = 1;
    localparam int IRQ_LANE = 0;
    localparam int RESULT_LSB = 0;
    localparam int RESULT_MSB = 15;

    typedef struct packed {
        logic [7:0] hyst;
        logic [15:0] upper;
        logic [15:0] lower;
    } thresh_t;

    typedef struct packed {
        logic activeOver;
        logic activeUnder;
        logic trippedOver;
        logic trippedUnder;
    } flags_t;

    typedef struct packed {
        thresh_t th;
        flags_t fl;
        logic [1:0] irqStatus;
        logic [1:0] irqMask;
        logic [31:0] datOut;
        logic [15:0] lastRes;
        logic ack;
        logic alarm;
        logic irq;
    } state_t;

    localparam state_t RESET_STATE = '{
        th: '{hyst: RESET_HYST, upper: RESET_UPPER, lower: RESET_LOWER},
        fl: '0,
        irqStatus: '0,
        irqMask: '0,
        datOut: '0,
        lastRes: '0,
        ack: 1'b0,
        alarm: 1'b0,
        irq: 1'b0
    };
endpackage
`default_nettype wire

// ### verilog/input_alarm_threshold_regs.sv
// Input alarm threshold registers, alarm flags and Wishbone slave
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module input_alarm_threshold_regs
    import alarm_threshold_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Wishbone slave
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [7:0] wbAdr,
    input wire logic [3:0] wbSel,
    input wire logic [31:0] wbDatIn,
    output logic [31:0] wbDatOut,
    output logic wbAck,
    // Conversion result, same clock
    input wire logic resultValid,
    input wire logic [15:0] result,
    // Alarm outputs
    output logic alarmOut,
    output logic irq
);
    // Reset release synchroniser
    logic rstMeta;
    logic rstSync;

    // All block state except the reset synchroniser in one word, and its next value
    state_t st;
    state_t next_st;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rstMeta <= 1'b0;
            rstSync <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstSync <= rstMeta;
        end
    end

    // Exact byte address match against a register base, low two bits included
    function automatic logic hits(input logic [7:0] adr, input logic [7:0] base);
        return adr == base;
    endfunction

    // Replace the byte lanes picked by sel and keep the others
    function automatic logic [31:0] mergeBytes(
        input logic [31:0] old,
        input logic [31:0] wd,
        input logic [3:0] sel
    );
        logic [31:0] r;
        r = old;
        for (int i = 0; i < LANES; i++) begin
            if (sel[i]) begin
                r[i*BYTE_W +: BYTE_W] = wd[i*BYTE_W +: BYTE_W];
            end
        end
        return r;
    endfunction

    // Upper word: hysteresis, reserved zero byte, upper limit
    function automatic logic [31:0] upperWord(input thresh_t t);
        return {t.hyst, RSV_UPPER, t.upper}; // see R1 R3 R7
    endfunction

    // Lower word: reserved zero half, lower limit
    function automatic logic [31:0] lowerWord(input thresh_t t);
        return {RSV_LOWER, t.lower}; // see R5 R8
    endfunction

    // Bus write into the threshold words; reserved bits are never stored
    function automatic thresh_t writeThresh(
        input thresh_t t,
        input logic wr,
        input logic [7:0] adr,
        input logic [31:0] wd,
        input logic [3:0] sel
    );
        thresh_t r;
        logic [31:0] w;
        r = t;
        w = READ_IDLE;
        if (wr && hits(adr, ADDR_UPPER)) begin
            w = mergeBytes(upperWord(t), wd, sel); // see R9
            r.hyst = w[HYST_LSB +: BYTE_W]; // see R1
            r.upper = w[LIMIT_LSB +: LIMIT_W]; // see R3 R7
        end
        if (wr && hits(adr, ADDR_LOWER)) begin
            w = mergeBytes(lowerWord(t), wd, sel); // see R10
            r.lower = w[LIMIT_LSB +: LIMIT_W]; // see R5 R8
        end
        return r;
    endfunction

    // Comparison ignores the two low limit bits
    function automatic logic [15:0] alignCmp(input logic [15:0] v);
        logic [15:0] r;
        r = v;
        r[CMP_LSB-1:0] = '0;
        return r;
    endfunction

    // Hysteresis nibble placed at the first compared bit
    function automatic logic [15:0] hystStep(input logic [7:0] h);
        logic [15:0] r;
        r = LIMIT_MIN;
        r[CMP_LSB +: HYST_W] = h[HYST_USED_LSB +: HYST_W]; // see R1
        return r;
    endfunction

    // Release point below the upper limit, floored at zero
    function automatic logic [15:0] relBelow(input logic [15:0] lim, input logic [15:0] step);
        logic [15:0] r;
        r = LIMIT_MIN;
        if (lim > step) begin
            r = lim - step;
        end
        return r;
    endfunction

    // Release point above the lower limit, capped at full scale
    function automatic logic [15:0] relAbove(input logic [15:0] lim, input logic [15:0] step);
        logic [15:0] r;
        r = LIMIT_MAX;
        if (LIMIT_MAX - lim > step) begin
            r = lim + step;
        end
        return r;
    endfunction

    // Over condition: set above the limit, held until below the release point
    function automatic logic holdOver(
        input logic cur,
        input logic [15:0] v,
        input logic [15:0] lim,
        input logic [15:0] rel
    );
        logic r;
        r = cur;
        if (v > lim) begin
            r = 1'b1;
        end else if (v < rel) begin
            r = 1'b0;
        end
        return r;
    endfunction

    // Under condition: mirror image of the over condition
    function automatic logic holdUnder(
        input logic cur,
        input logic [15:0] v,
        input logic [15:0] lim,
        input logic [15:0] rel
    );
        logic r;
        r = cur;
        if (v < lim) begin
            r = 1'b1;
        end else if (v > rel) begin
            r = 1'b0;
        end
        return r;
    endfunction

    // Tripped flags: cleared by a status read, a live condition sets them again
    function automatic flags_t nextTripped(input flags_t f, input logic clear);
        flags_t r;
        r = f;
        if (clear) begin
            r.trippedOver = 1'b0;
            r.trippedUnder = 1'b0;
        end
        if (f.activeOver) begin
            r.trippedOver = 1'b1; // see R11
        end
        if (f.activeUnder) begin
            r.trippedUnder = 1'b1; // see R11
        end
        return r;
    endfunction

    // Interrupt status: write one to clear, a new event wins in the same cycle
    function automatic logic [1:0] nextIrqStatus(
        input logic [1:0] cur,
        input logic [1:0] clr,
        input logic [1:0] events
    );
        return (cur & ~clr) | events;
    endfunction

    // Flag word as software reads it
    function automatic logic [31:0] statusWord(input flags_t f);
        logic [31:0] r;
        r = READ_IDLE;
        r[ACT_OVER_BIT] = f.activeOver; // see R11
        r[ACT_UNDER_BIT] = f.activeUnder; // see R11
        r[TRIP_OVER_BIT] = f.trippedOver; // see R11
        r[TRIP_UNDER_BIT] = f.trippedUnder; // see R11
        r[SUMMARY_BIT] = f.trippedOver | f.trippedUnder; // see R12
        return r;
    endfunction

    // Read multiplexer; unmapped addresses read as zero
    function automatic logic [31:0] readWord(input state_t s, input logic [7:0] adr);
        logic [31:0] r;
        r = READ_IDLE;
        case (adr)
            ADDR_UPPER: begin
                r = upperWord(s.th); // see R7 R9
            end
            ADDR_LOWER: begin
                r = lowerWord(s.th); // see R8 R10
            end
            ADDR_STATUS: begin
                r = statusWord(s.fl); // see R11 R12
            end
            ADDR_IRQ_STATUS: begin
                r[IRQ_MSB:IRQ_LSB] = s.irqStatus;
            end
            ADDR_IRQ_MASK: begin
                r[IRQ_MSB:IRQ_LSB] = s.irqMask;
            end
            ADDR_RESULT: begin
                r[RESULT_MSB:RESULT_LSB] = s.lastRes;
            end
            default: begin
                r = READ_IDLE;
            end
        endcase
        return r;
    endfunction

    always_comb begin
        logic access;
        logic reqWr;
        logic clrTrip;
        logic [15:0] step;
        logic [15:0] upCmp;
        logic [15:0] loCmp;
        logic [15:0] resCmp;
        logic [15:0] upRel;
        logic [15:0] loRel;
        logic [1:0] events;
        logic [1:0] clrIrq;
        access = wbCyc && wbStb && !st.ack;
        reqWr = access && wbWe;
        clrTrip = access && !wbWe && hits(wbAdr, ADDR_STATUS);
        step = hystStep(st.th.hyst); // see R1
        upCmp = alignCmp(st.th.upper); // see R3
        loCmp = alignCmp(st.th.lower); // see R5
        resCmp = alignCmp(result);
        upRel = relBelow(upCmp, step); // see R13
        loRel = relAbove(loCmp, step); // see R13
        events = '0;
        clrIrq = '0;
        next_st = st;

        // One-cycle acknowledge; read data stands only beside it
        next_st.ack = access;
        next_st.datOut = READ_IDLE;
        if (access) begin
            next_st.datOut = readWord(st, wbAdr);
        end

        // Threshold words
        next_st.th = writeThresh(st.th, reqWr, wbAdr, wbDatIn, wbSel);

        // Alarm conditions follow each new conversion result
        if (resultValid) begin
            next_st.lastRes = result;
            next_st.fl.activeOver = holdOver(st.fl.activeOver, resCmp, upCmp, upRel); // see R13
            next_st.fl.activeUnder = holdUnder(st.fl.activeUnder, resCmp, loCmp, loRel); // see R13
        end
        next_st.fl = nextTripped(next_st.fl, clrTrip); // see R11
        next_st.alarm = next_st.fl.trippedOver | next_st.fl.trippedUnder; // see R12

        // Interrupt events on the rising edge of each active flag
        events[IRQ_OVER_BIT] = next_st.fl.activeOver & ~st.fl.activeOver;
        events[IRQ_UNDER_BIT] = next_st.fl.activeUnder & ~st.fl.activeUnder;
        if (reqWr && hits(wbAdr, ADDR_IRQ_STATUS) && wbSel[IRQ_LANE]) begin
            clrIrq = wbDatIn[IRQ_MSB:IRQ_LSB];
        end
        if (reqWr && hits(wbAdr, ADDR_IRQ_MASK) && wbSel[IRQ_LANE]) begin
            next_st.irqMask = wbDatIn[IRQ_MSB:IRQ_LSB];
        end
        next_st.irqStatus = nextIrqStatus(st.irqStatus, clrIrq, events);
        next_st.irq = |(next_st.irqStatus & next_st.irqMask);
    end

    // State register; reset values come from the package
    always_ff @(posedge ref_clk or negedge rstSync) begin
        if (!rstSync) begin
            st <= RESET_STATE;
        end else begin
            st <= next_st;
        end
    end

    // Every output comes straight from the state register
    assign wbDatOut = st.datOut;
    assign wbAck = st.ack;
    assign irq = st.irq;
    assign alarmOut = st.alarm; // see R12
endmodule // input_alarm_threshold_regs
`default_nettype wire

// ### testbench/input_alarm_threshold_regs_sva.sv
// Port assertions for the alarm threshold registers
`timescale 1ns/1ps
`default_nettype none
module input_alarm_threshold_regs_sva
    import alarm_threshold_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Bus
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [7:0] wbAdr,
    input wire logic [3:0] wbSel,
    input wire logic [31:0] wbDatIn,
    input wire logic [31:0] wbDatOut,
    input wire logic wbAck,
    // Result and alarms
    input wire logic resultValid,
    input wire logic [15:0] result,
    input wire logic alarmOut,
    input wire logic irq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    wire logic rd = wbAck && !wbWe;
    wire logic st = rd && wbAdr == ADDR_STATUS;
    ack_pulse_a: assert property (wbAck |=> !wbAck) else $error("long ack");
    ack_answer_a: assert property (wbCyc && wbStb && !wbAck |=> wbAck) else $error("no ack");
    idle_zero_a: assert property (!wbAck |-> wbDatOut == 32'h0) else $error("data not idle");
    upper_rsv_a: assert property (rd && wbAdr == ADDR_UPPER |-> wbDatOut[23:16] == 8'h00) else $error("rsv");
    lower_rsv_a: assert property (rd && wbAdr == ADDR_LOWER |-> wbDatOut[31:16] == 16'h0) else $error("rsv");
    summary_or_a: assert property (st |-> wbDatOut[0] == |wbDatOut[5:4]) else $error("summary");
    trip_held_a: assert property (st |-> (wbDatOut[5:4] & wbDatOut[11:10]) == wbDatOut[11:10]) else $error("trip");
    alarm_cause_a: assert property ($rose(alarmOut) |-> $past(resultValid) || $past(resultValid, 2)) else $error("alarm");
    over_seen_c: cover property (st && wbDatOut[10]);
    under_seen_c: cover property (st && wbDatOut[11]);
    irq_clear_c: cover property ($fell(irq));
endmodule // input_alarm_threshold_regs_sva
bind input_alarm_threshold_regs input_alarm_threshold_regs_sva sva_u (.ref_clk, .rst_b, .wbCyc, .wbStb,
    .wbWe, .wbAdr, .wbSel, .wbDatIn, .wbDatOut, .wbAck, .resultValid, .result, .alarmOut, .irq);
`default_nettype wire

// ### testbench/wb_host_model.sv
// Wishbone host issuing classic single cycles
`timescale 1ns/1ps
`default_nettype none
module wb_host_model
    import alarm_threshold_pkg::*;
(
    // Clock and answer
    input wire logic ref_clk,
    input wire logic wbAck,
    input wire logic [31:0] wbDatOut,
    // Request
    output logic wbCyc,
    output logic wbStb,
    output logic wbWe,
    output logic [7:0] wbAdr,
    output logic [3:0] wbSel,
    output logic [31:0] wbDatIn
);
    initial {wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatIn} = '0;
    task automatic xfer(input logic we, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d,
                        output logic [31:0] q);
        wbDatIn <= d & ~(a == ADDR_UPPER ? 32'h0f000003 : a == ADDR_LOWER ? 32'h3 : 32'h0);
        {wbCyc, wbStb, wbWe, wbAdr, wbSel} <= {2'b11, we, a, s};
        do @(posedge ref_clk); while (wbAck !== 1'b1);
        q = wbDatOut;
        {wbCyc, wbStb} <= 2'b00;
        @(posedge ref_clk);
    endtask
endmodule // wb_host_model
`default_nettype wire

// ### testbench/input_alarm_threshold_regs_tb_top.sv
// Self-checking bench for the alarm threshold registers
`timescale 1ns/1ps
`default_nettype none
module input_alarm_threshold_regs_tb_top;
    import alarm_threshold_pkg::*;
    logic ref_clk = 1'b0, rst_b = 1'b0, resultValid = 1'b0, wbCyc, wbStb, wbWe, wbAck, alarmOut, irq;
    logic [15:0] result = 16'h0;
    logic [7:0] wbAdr;
    logic [3:0] wbSel, s;
    logic [31:0] wbDatIn, wbDatOut, q, d, mUp, mLo;
    int seed = 63, miscompares = 0, comparisons = 0, cycles = 0;
    always #2.5 ref_clk = ~ref_clk;
    input_alarm_threshold_regs dut_u (.ref_clk, .rst_b, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel, .wbDatIn,
        .wbDatOut, .wbAck, .resultValid, .result, .alarmOut, .irq);
    wb_host_model host_u (.ref_clk, .wbAck, .wbDatOut, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel, .wbDatIn);
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        host_u.xfer(1'b0, a, 4'hf, 32'h0, q);
        check("read data", q, exp);
    endtask
    // Byte-lane merge, then the bits that read back as stored
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] v, input logic [31:0] keep);
        for (int i = 0; i < 4; i++) if (s[i]) o[8*i+:8] = v[8*i+:8];
        return o & keep;
    endfunction
    task automatic conv(input logic [15:0] r, input logic [31:0] exp);
        result <= r;
        resultValid <= 1'b1;
        @(posedge ref_clk);
        resultValid <= 1'b0;
        repeat (3) @(posedge ref_clk);
        check("alarm", alarmOut, exp[0]);
        rd(ADDR_STATUS, exp);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge ref_clk) if (++cycles == 20000) begin
        miscompares++;
        wrap_up();
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rd(ADDR_UPPER, 32'h0000ffff);
        rd(ADDR_LOWER, 32'h0);
        mUp = 32'h0000ffff;
        mLo = 32'h0;
        for (int i = 0; i < 12; i++) begin
            d = $random(seed);
            s = i < 4 ? 4'h1 << i : 4'($random(seed));
            host_u.xfer(1'b1, ADDR_UPPER, s, d, q);
            mUp = merge(mUp, d, 32'hf000fffc);
            rd(ADDR_UPPER, mUp);
            host_u.xfer(1'b1, ADDR_LOWER, s, ~d, q);
            mLo = merge(mLo, ~d, 32'h0000fffc);
            rd(ADDR_LOWER, mLo);
        end
        host_u.xfer(1'b1, 8'h3c, 4'hf, d, q);
        rd(8'h3c, 32'h0);
        $display("byte lane test done");
        host_u.xfer(1'b1, ADDR_UPPER, 4'hf, 32'h10001000, q);
        host_u.xfer(1'b1, ADDR_LOWER, 4'hf, 32'h00000100, q);
        conv(16'h1004, 32'h411);
        conv(16'h0ffc, 32'h411);
        conv(16'h0ff8, 32'h011);
        rd(ADDR_STATUS, 32'h0);
        conv(16'h00f8, 32'h821);
        rd(ADDR_RESULT, 32'h000000f8);
        check("irq", irq, 32'h0);
        rd(ADDR_IRQ_STATUS, 32'h3);
        host_u.xfer(1'b1, ADDR_IRQ_MASK, 4'hf, 32'h1, q);
        rd(ADDR_IRQ_MASK, 32'h1);
        repeat (2) @(posedge ref_clk);
        check("irq", irq, 32'h1);
        host_u.xfer(1'b1, ADDR_IRQ_STATUS, 4'hf, 32'h3, q);
        repeat (2) @(posedge ref_clk);
        check("irq", irq, 32'h0);
        $display("alarm and irq test done");
        wrap_up();
    end
endmodule // input_alarm_threshold_regs_tb_top
`default_nettype wire
